/* File: src/gmp_pkg.sv */
// shared constants, types and helpers of the byte-wide mac port
package gmp_pkg;
   // clock rates in hertz
   localparam int unsigned CLK_HZ     = 200_000_000;
   localparam int unsigned F10_HZ     = 2_500_000;
   localparam int unsigned F100_HZ    = 25_000_000;
   localparam int unsigned F1000_HZ   = 125_000_000;
   // shortest half period that keeps launch and capture apart
   localparam int unsigned MIN_HALF   = 2;
   localparam int unsigned HALF_W     = 8;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned ERR_BIT    = 8;
   localparam int unsigned RX_WORD_W  = 9;

   typedef enum logic [1:0] {
      SPD_10   = 2'h0,
      SPD_100  = 2'h1,
      SPD_1000 = 2'h2
   } gmp_speed_e;

   // one sampled lane: clock, data byte, two control lines
   typedef struct packed {
      logic       clk;
      logic [7:0] d;
      logic       c0;
      logic       c1;
   } gmp_lane_s;

   // half period of the link clock in system clock cycles
   function automatic logic [HALF_W-1:0] gmp_half(input gmp_speed_e spd);
      int unsigned f;
      int unsigned h;
      case (spd)
         SPD_10:  f = F10_HZ;
         SPD_100: f = F100_HZ;
         default: f = F1000_HZ;
      endcase
      h = CLK_HZ / (2 * f);
      if (h < MIN_HALF) begin
         h = MIN_HALF;
      end
      return h[HALF_W-1:0];
   endfunction : gmp_half
endpackage : gmp_pkg

/* File: src/gmp_link_if.sv */
// pins between the transceiver end and the mac end of the port
`timescale 1ns/1ps
`default_nettype none
interface gmp_link_if;
   logic       rx_clk;
   logic [7:0] rxd;
   logic       rx_dv;
   logic       rx_ctl;
   logic       tx_clk;
   logic       gtx_clk;
   logic [7:0] txd;
   logic       tx_en;
   logic       tx_ctl;
   logic       crs;
   logic       col;

   modport phy (
      output rx_clk, rxd, rx_dv, rx_ctl, tx_clk, crs, col,
      input  gtx_clk, txd, tx_en, tx_ctl
   );
   modport mac (
      input  rx_clk, rxd, rx_dv, rx_ctl, tx_clk, crs, col,
      output gtx_clk, txd, tx_en, tx_ctl
   );
endinterface : gmp_link_if
`default_nettype wire

/* File: src/gmp_phy_end.sv */
// transceiver end of the port with its receive fifo
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// receive fifo
// ****************************************
module gmp_fifo
   import gmp_pkg::*;
#(
   parameter int unsigned WIDTH = RX_WORD_W,
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output var  logic             in_ready_o,
   output var  logic [WIDTH-1:0] out_data_o,
   output var  logic             out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned PW = AW + 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr, next_wr_ptr;
   logic [PW-1:0]    rd_ptr, next_rd_ptr;
   logic             next_ready;
   logic             push, pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_param_chk
      $error("fifo needs a power of two depth of at least 2 and a width of at least 1");
   end

   assign out_valid_o = (wr_ptr != rd_ptr);
   assign out_data_o  = mem[rd_ptr[AW-1:0]];

   always_comb begin
      push        = in_valid_i && in_ready_o;
      pop         = out_valid_o && out_ready_i;
      next_wr_ptr = wr_ptr + PW'(push);
      next_rd_ptr = rd_ptr + PW'(pop);
      next_ready  = (PW'(next_wr_ptr - next_rd_ptr) != PW'(DEPTH));
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr     <= '0;
         rd_ptr     <= '0;
         in_ready_o <= 1'b0;
      end else begin
         wr_ptr     <= next_wr_ptr;
         rd_ptr     <= next_rd_ptr;
         in_ready_o <= next_ready;
         if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
         end
      end
   end
endmodule : gmp_fifo

// ****************************************
// transceiver end
// ****************************************
module gmp_phy_end
   import gmp_pkg::*;
#(
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input  wire logic       CLOCK_I,
   input  wire logic       RST_N_I,
   gmp_link_if.phy         LINK,
   input  wire logic       MODE_RGMII_I,
   input  wire gmp_speed_e SPEED_I,
   input  wire logic [7:0] RX_DATA_I,
   input  wire logic       RX_ER_I,
   input  wire logic       RX_VALID_I,
   output var  logic       RX_READY_O,
   input  wire logic       CARRIER_I,
   input  wire logic       COLLISION_I,
   input  wire logic       FULL_DUPLEX_I,
   output var  logic [7:0] TX_DATA_O,
   output var  logic       TX_VALID_O,
   output var  logic       TX_ER_O
);
   logic [HALF_W-1:0]    half;
   logic [HALF_W-1:0]    div_cnt, next_div_cnt;
   logic                 div_clk, next_div_clk;
   logic                 launch;
   logic [RX_WORD_W-1:0] fifo_data;
   logic                 fifo_valid, fifo_pop;
   logic [RX_WORD_W-1:0] cur_word, next_cur_word;
   logic                 cur_dv, next_cur_dv;
   logic [7:0]           rxd, next_rxd;
   logic                 rx_dv, next_rx_dv;
   logic                 rx_ctl, next_rx_ctl;
   logic                 crs, next_crs;
   logic                 col, next_col;
   logic [1:0]           dclk_d;
   logic                 tx_ref;
   gmp_lane_s            tx_s1, tx_s2;
   logic                 ref_d;
   logic                 t_rise, t_fall;
   logic [3:0]           tx_lo, next_tx_lo;
   logic                 en_cap, next_en_cap;
   logic [7:0]           next_tx_data;
   logic                 next_tx_valid, next_tx_er;

   gmp_fifo #(
      .WIDTH (RX_WORD_W),
      .DEPTH (DEPTH)
   ) u_rx_fifo (
      .clk_i       (CLOCK_I),
      .rst_n_i     (RST_N_I),
      .in_data_i   ({RX_ER_I, RX_DATA_I}),
      .in_valid_i  (RX_VALID_I),
      .in_ready_o  (RX_READY_O),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop)
   );

   // ****************************************
   // link clocks and receive launch
   // ****************************************
   assign LINK.rx_clk = div_clk;
   assign LINK.tx_clk = div_clk;
   assign LINK.rxd    = rxd;
   assign LINK.rx_dv  = rx_dv;
   assign LINK.rx_ctl = rx_ctl;
   assign LINK.crs    = crs;
   assign LINK.col    = col;

   always_comb begin
      half          = gmp_half(SPEED_I);
      next_div_cnt  = div_cnt + HALF_W'(1);
      next_div_clk  = div_clk;
      if (div_cnt >= half - HALF_W'(1)) begin
         next_div_cnt = '0;
         next_div_clk = !div_clk;
      end
      // one cycle after a clock change the next half's data is set up
      launch        = (div_cnt == '0);
      fifo_pop      = launch && !div_clk;
      next_cur_word = cur_word;
      next_cur_dv   = cur_dv;
      next_rxd      = rxd;
      next_rx_dv    = rx_dv;
      next_rx_ctl   = rx_ctl;
      if (fifo_pop) begin
         next_cur_word = fifo_valid ? fifo_data : '0;
         next_cur_dv   = fifo_valid;
         if (MODE_RGMII_I) begin
            next_rxd    = {4'h0, next_cur_word[3:0]};
            next_rx_dv  = 1'b0;
            next_rx_ctl = fifo_valid;
         end else begin
            next_rxd    = next_cur_word[7:0];
            next_rx_dv  = fifo_valid;
            next_rx_ctl = next_cur_word[ERR_BIT];
         end
      end else if (launch && MODE_RGMII_I) begin
         next_rxd    = {4'h0, cur_word[7:4]};
         next_rx_ctl = cur_dv ^ cur_word[ERR_BIT];
      end
      next_crs = !MODE_RGMII_I && CARRIER_I;
      next_col = !MODE_RGMII_I && COLLISION_I && !FULL_DUPLEX_I;
   end

   // ****************************************
   // transmit capture
   // ****************************************
   // own clock below gigabit in byte mode, else the mac clock; both two flops late
   assign tx_ref = (!MODE_RGMII_I && SPEED_I != SPD_1000) ? dclk_d[1] : tx_s2.clk;

   always_comb begin
      t_rise        = tx_ref && !ref_d;
      t_fall        = !tx_ref && ref_d;
      next_tx_lo    = tx_lo;
      next_en_cap   = en_cap;
      next_tx_data  = TX_DATA_O;
      next_tx_valid = 1'b0;
      next_tx_er    = TX_ER_O;
      if (!MODE_RGMII_I) begin
         if (t_rise && tx_s2.c0) begin
            next_tx_data  = tx_s2.d;
            next_tx_valid = 1'b1;
            next_tx_er    = tx_s2.c1;
         end
      end else begin
         if (t_rise) begin
            next_tx_lo  = tx_s2.d[3:0];
            next_en_cap = tx_s2.c1;
         end
         if (t_fall && en_cap) begin
            next_tx_data  = {tx_s2.d[3:0], tx_lo};
            next_tx_valid = 1'b1;
            next_tx_er    = en_cap ^ tx_s2.c1;
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         div_cnt    <= '0;
         div_clk    <= 1'b0;
         cur_word   <= '0;
         cur_dv     <= 1'b0;
         rxd        <= 8'h00;
         rx_dv      <= 1'b0;
         rx_ctl     <= 1'b0;
         crs        <= 1'b0;
         col        <= 1'b0;
         tx_s1      <= '0;
         tx_s2      <= '0;
         dclk_d     <= 2'h0;
         ref_d      <= 1'b0;
         tx_lo      <= 4'h0;
         en_cap     <= 1'b0;
         TX_DATA_O  <= 8'h00;
         TX_VALID_O <= 1'b0;
         TX_ER_O    <= 1'b0;
      end else begin
         div_cnt    <= next_div_cnt;
         div_clk    <= next_div_clk;
         cur_word   <= next_cur_word;
         cur_dv     <= next_cur_dv;
         rxd        <= next_rxd;
         rx_dv      <= next_rx_dv;
         rx_ctl     <= next_rx_ctl;
         crs        <= next_crs;
         col        <= next_col;
         tx_s1      <= {LINK.gtx_clk, LINK.txd, LINK.tx_en, LINK.tx_ctl};
         tx_s2      <= tx_s1;
         dclk_d     <= {dclk_d[0], div_clk};
         ref_d      <= tx_ref;
         tx_lo      <= next_tx_lo;
         en_cap     <= next_en_cap;
         TX_DATA_O  <= next_tx_data;
         TX_VALID_O <= next_tx_valid;
         TX_ER_O    <= next_tx_er;
      end
   end
endmodule : gmp_phy_end
`default_nettype wire

/* File: src/gmp_mac_end.sv */
// mac end of the byte-wide port
`timescale 1ns/1ps
`default_nettype none
module gmp_mac_end
   import gmp_pkg::*;
(
   input  wire logic       CLOCK_I,
   input  wire logic       RST_N_I,
   gmp_link_if.mac         LINK,
   input  wire logic       MODE_RGMII_I,
   input  wire gmp_speed_e SPEED_I,
   input  wire logic [7:0] TX_DATA_I,
   input  wire logic       TX_ER_I,
   input  wire logic       TX_VALID_I,
   output var  logic       TX_READY_O,
   output var  logic [7:0] RX_DATA_O,
   output var  logic       RX_VALID_O,
   output var  logic       RX_ER_O,
   output var  logic       CRS_O,
   output var  logic       COL_O
);
   // ****************************************
   // declarations
   // ****************************************
   logic [HALF_W-1:0] half;
   logic [HALF_W-1:0] div_cnt;
   logic [HALF_W-1:0] next_div_cnt;
   logic              gtx;
   logic              next_gtx;
   logic              own;
   logic              set_rise;
   logic              set_fall;
   logic              tref_s1;
   logic              tref_s2;
   logic              tref_d;
   logic              take;
   logic              hold_full;
   logic              next_hold_full;
   logic [7:0]        hold_data;
   logic [7:0]        next_hold_data;
   logic              hold_er;
   logic              next_hold_er;
   logic [7:0]        txd;
   logic [7:0]        next_txd;
   logic              tx_en;
   logic              next_tx_en;
   logic              tx_ctl;
   logic              next_tx_ctl;
   logic [3:0]        hi_nib;
   logic [3:0]        next_hi_nib;
   logic              hi_ctl;
   logic              next_hi_ctl;
   gmp_lane_s         rx_s1;
   gmp_lane_s         rx_s2;
   logic              rref_d;
   logic              r_rise;
   logic              r_fall;
   logic [3:0]        rx_lo;
   logic [3:0]        next_rx_lo;
   logic              dv_cap;
   logic              next_dv_cap;
   logic [7:0]        next_rx_data;
   logic              next_rx_valid;
   logic              next_rx_er;
   logic [1:0]        cs_s1;
   logic [1:0]        cs_s2;

   assign LINK.gtx_clk = gtx;
   assign LINK.txd     = txd;
   assign LINK.tx_en   = tx_en;
   assign LINK.tx_ctl  = tx_ctl;

   // ****************************************
   // transmit clock and launch
   // ****************************************
   always_comb begin
      own          = MODE_RGMII_I || SPEED_I == SPD_1000;
      half         = gmp_half(SPEED_I);
      next_div_cnt = div_cnt + HALF_W'(1);
      next_gtx     = gtx;
      if (div_cnt >= half - HALF_W'(1)) begin
         next_div_cnt = '0;
         next_gtx     = !gtx;
      end
      if (!own) begin
         next_div_cnt = '0;
         next_gtx     = 1'b0;
      end
      // data is set up one cycle after the opposite edge of gtx, or three cycles after a falling tx_clk when gtx is off
      if (own) begin
         set_rise = (div_cnt == '0) && !gtx;
         set_fall = (div_cnt == '0) && gtx && MODE_RGMII_I;
      end else begin
         set_rise = !tref_s2 && tref_d;
         set_fall = 1'b0;
      end
      take           = TX_VALID_I && TX_READY_O;
      next_hold_data = take ? TX_DATA_I : hold_data;
      next_hold_er   = take ? TX_ER_I : hold_er;
      next_hold_full = take || (hold_full && !set_rise);
      next_txd       = txd;
      next_tx_en     = tx_en;
      next_tx_ctl    = tx_ctl;
      next_hi_nib    = hi_nib;
      next_hi_ctl    = hi_ctl;
      if (set_rise) begin
         if (MODE_RGMII_I) begin
            next_txd    = {4'h0, hold_full ? hold_data[3:0] : 4'h0};
            next_tx_en  = 1'b0;
            next_tx_ctl = hold_full;
            next_hi_nib = hold_full ? hold_data[7:4] : 4'h0;
            next_hi_ctl = hold_full ^ (hold_full && hold_er);
         end else begin
            next_txd    = hold_full ? hold_data : 8'h00;
            next_tx_en  = hold_full;
            next_tx_ctl = hold_full && hold_er;
         end
      end else if (set_fall) begin
         next_txd    = {4'h0, hi_nib};
         next_tx_ctl = hi_ctl;
      end
   end

   // ****************************************
   // receive capture
   // ****************************************
   always_comb begin
      r_rise        = rx_s2.clk && !rref_d;
      r_fall        = !rx_s2.clk && rref_d;
      next_rx_lo    = rx_lo;
      next_dv_cap   = dv_cap;
      next_rx_data  = RX_DATA_O;
      next_rx_valid = 1'b0;
      next_rx_er    = RX_ER_O;
      if (!MODE_RGMII_I) begin
         if (r_rise && rx_s2.c0) begin
            next_rx_data  = rx_s2.d;
            next_rx_valid = 1'b1;
            next_rx_er    = rx_s2.c1;
         end
      end else begin
         if (r_rise) begin
            next_rx_lo  = rx_s2.d[3:0];
            next_dv_cap = rx_s2.c1;
         end
         if (r_fall && dv_cap) begin
            next_rx_data  = {rx_s2.d[3:0], rx_lo};
            next_rx_valid = 1'b1;
            next_rx_er    = dv_cap ^ rx_s2.c1;
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         div_cnt    <= '0;
         gtx        <= 1'b0;
         tref_s1    <= 1'b0;
         tref_s2    <= 1'b0;
         tref_d     <= 1'b0;
         hold_full  <= 1'b0;
         hold_data  <= 8'h00;
         hold_er    <= 1'b0;
         TX_READY_O <= 1'b0;
         txd        <= 8'h00;
         tx_en      <= 1'b0;
         tx_ctl     <= 1'b0;
         hi_nib     <= 4'h0;
         hi_ctl     <= 1'b0;
         rx_s1      <= '0;
         rx_s2      <= '0;
         rref_d     <= 1'b0;
         rx_lo      <= 4'h0;
         dv_cap     <= 1'b0;
         RX_DATA_O  <= 8'h00;
         RX_VALID_O <= 1'b0;
         RX_ER_O    <= 1'b0;
         cs_s1      <= 2'h0;
         cs_s2      <= 2'h0;
         CRS_O      <= 1'b0;
         COL_O      <= 1'b0;
      end else begin
         div_cnt    <= next_div_cnt;
         gtx        <= next_gtx;
         tref_s1    <= LINK.tx_clk;
         tref_s2    <= tref_s1;
         tref_d     <= tref_s2;
         hold_full  <= next_hold_full;
         hold_data  <= next_hold_data;
         hold_er    <= next_hold_er;
         TX_READY_O <= !next_hold_full;
         txd        <= next_txd;
         tx_en      <= next_tx_en;
         tx_ctl     <= next_tx_ctl;
         hi_nib     <= next_hi_nib;
         hi_ctl     <= next_hi_ctl;
         rx_s1      <= {LINK.rx_clk, LINK.rxd, LINK.rx_dv, LINK.rx_ctl};
         rx_s2      <= rx_s1;
         rref_d     <= rx_s2.clk;
         rx_lo      <= next_rx_lo;
         dv_cap     <= next_dv_cap;
         RX_DATA_O  <= next_rx_data;
         RX_VALID_O <= next_rx_valid;
         RX_ER_O    <= next_rx_er;
         cs_s1      <= {LINK.crs, LINK.col};
         cs_s2      <= cs_s1;
         CRS_O      <= cs_s2[1] && !MODE_RGMII_I;
         COL_O      <= cs_s2[0] && !MODE_RGMII_I;
      end
   end
endmodule : gmp_mac_end
`default_nettype wire

/* File: bench/gmp_link_checker.sv */
// assertions on the pins between the transceiver end and the mac end
`timescale 1ns/1ps
`default_nettype none
module gmp_link_checker
   import gmp_pkg::*;
(
   input wire logic       CLOCK_I,
   input wire logic       RST_N_I,
   input wire logic       MODE_RGMII_I,
   input wire gmp_speed_e SPEED_I,
   input wire logic       rx_clk,
   input wire logic [7:0] rxd,
   input wire logic       rx_dv,
   input wire logic       rx_ctl,
   input wire logic       tx_clk,
   input wire logic       gtx_clk,
   input wire logic [7:0] txd,
   input wire logic       tx_en,
   input wire logic       tx_ctl,
   input wire logic       crs,
   input wire logic       col
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   // ****************************************
   // half period counters of both transmit clocks
   // ****************************************
   logic [1:0]      clks, prev, next_prev, seen, next_seen;
   logic [1:0][7:0] run, next_run;
   logic [7:0]      half;
   logic            gtx_on;
   assign clks   = {gtx_clk, tx_clk};
   assign gtx_on = MODE_RGMII_I || SPEED_I == SPD_1000;
   assign half   = SPEED_I == SPD_10 ? 8'h28 : SPEED_I == SPD_100 ? 8'h04 : 8'h02;
   always_comb begin
      next_prev = clks;
      next_seen = seen;
      next_run  = run;
      for (int i = 0; i < 2; i++) begin
         if (clks[i] != prev[i]) begin
            next_run[i]  = 8'h01;
            next_seen[i] = 1'b1;
         end else if (run[i] != 8'hFF) begin
            next_run[i] = run[i] + 8'h01;
         end
      end
   end
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         prev <= 2'h0;
         seen <= 2'h0;
         run  <= '0;
      end else begin
         prev <= next_prev;
         seen <= next_seen;
         run  <= next_run;
      end
   end
   a_txclk_half: assert property (seen[0] && tx_clk != prev[0] |-> run[0] == half)
      else $error("tx clock half period wrong");
   a_gtx_half: assert property (gtx_on && seen[1] && gtx_clk != prev[1] |-> run[1] == half)
      else $error("gtx clock half period wrong");
   a_rx_byte_rise: assert property (!MODE_RGMII_I && $rose(rx_clk) |-> $stable(rxd) && $stable(rx_dv) && $stable(rx_ctl))
      else $error("receive byte lines move at rising edge");
   a_rx_nib_edges: assert property (MODE_RGMII_I && $changed(rx_clk) |-> $stable(rxd[3:0]) && $stable(rx_ctl))
      else $error("receive nibble lines move at clock edge");
   a_tx_byte_rise: assert property (!MODE_RGMII_I && $rose(gtx_on ? gtx_clk : tx_clk) |-> $stable(txd) && $stable(tx_en) && $stable(tx_ctl))
      else $error("transmit byte lines move at rising edge");
   a_tx_nib_edges: assert property (MODE_RGMII_I && $changed(gtx_clk) |-> $stable(txd[3:0]) && $stable(tx_ctl))
      else $error("transmit nibble lines move at clock edge");
   a_nib_unused: assert property (MODE_RGMII_I |-> rxd[7:4] == 4'h0 && !rx_dv && txd[7:4] == 4'h0 && !tx_en)
      else $error("unused lines driven in nibble mode");
   a_nib_no_sense: assert property (MODE_RGMII_I |-> !crs && !col)
      else $error("carrier or collision driven in nibble mode");
   cover property (MODE_RGMII_I && $fell(rx_clk) && rx_ctl);
   cover property (MODE_RGMII_I && $rose(gtx_clk) && tx_ctl);
   cover property (!MODE_RGMII_I && col);
endmodule : gmp_link_checker
`default_nettype wire

/* File: bench/gmp_port_test.sv */
// self-checking bench joining the transceiver end and the mac end
`timescale 1ns/1ps
`default_nettype none
module gmp_port_test
   import gmp_pkg::*;
;
   logic        clk = 1'b0, rst_n = 1'b0, mode = 1'b0;
   gmp_speed_e  speed = SPD_10;
   logic [7:0]  prx_d = 8'h00, mtx_d = 8'h00, ptx_d, mrx_d;
   logic        prx_er = 1'b0, prx_v = 1'b0, mtx_er = 1'b0, mtx_v = 1'b0;
   logic        carrier = 1'b0, coll = 1'b0, fdx = 1'b0, full_seen;
   logic        prx_rdy, mtx_rdy, ptx_v, ptx_er, mrx_v, mrx_er, crs_o, col_o;
   logic [31:0] seed = 32'h0000_0007;
   logic [8:0]  rxq[$], txq[$];
   int          fail_count = 0, num_checks = 0, cyc = 0;

   always #2.5 clk = ~clk;

   gmp_link_if gmp_link_if_inst ();
   gmp_phy_end #(.DEPTH(FIFO_DEPTH)) gmp_phy_end_inst (.CLOCK_I(clk), .RST_N_I(rst_n),
      .LINK(gmp_link_if_inst), .MODE_RGMII_I(mode), .SPEED_I(speed), .RX_DATA_I(prx_d),
      .RX_ER_I(prx_er), .RX_VALID_I(prx_v), .RX_READY_O(prx_rdy), .CARRIER_I(carrier),
      .COLLISION_I(coll), .FULL_DUPLEX_I(fdx), .TX_DATA_O(ptx_d), .TX_VALID_O(ptx_v),
      .TX_ER_O(ptx_er));
   gmp_mac_end gmp_mac_end_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .LINK(gmp_link_if_inst),
      .MODE_RGMII_I(mode), .SPEED_I(speed), .TX_DATA_I(mtx_d), .TX_ER_I(mtx_er),
      .TX_VALID_I(mtx_v), .TX_READY_O(mtx_rdy), .RX_DATA_O(mrx_d), .RX_VALID_O(mrx_v),
      .RX_ER_O(mrx_er), .CRS_O(crs_o), .COL_O(col_o));
   gmp_link_checker gmp_link_checker_inst (.CLOCK_I(clk), .RST_N_I(rst_n),
      .MODE_RGMII_I(mode), .SPEED_I(speed), .rx_clk(gmp_link_if_inst.rx_clk),
      .rxd(gmp_link_if_inst.rxd), .rx_dv(gmp_link_if_inst.rx_dv),
      .rx_ctl(gmp_link_if_inst.rx_ctl), .tx_clk(gmp_link_if_inst.tx_clk),
      .gtx_clk(gmp_link_if_inst.gtx_clk), .txd(gmp_link_if_inst.txd),
      .tx_en(gmp_link_if_inst.tx_en), .tx_ctl(gmp_link_if_inst.tx_ctl),
      .crs(gmp_link_if_inst.crs), .col(gmp_link_if_inst.col));

   // ****************************************
   // tasks
   // ****************************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   task automatic chk_word(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic summarize();
      if (fail_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize

   // ready is registered, so its value at the falling edge is what the next rising edge sees
   task automatic push_rx(input logic [8:0] w);
      logic r;
      int   n;
      n = 0;
      rxq.push_back(w);
      {prx_er, prx_d} = w;
      prx_v = 1'b1;
      do begin
         r = prx_rdy === 1'b1;
         full_seen |= !r;
         @(negedge clk);
         n++;
      end while (!r && n < 4000);
   endtask : push_rx

   task automatic push_tx(input logic [8:0] w);
      logic r;
      int   n;
      n = 0;
      txq.push_back(w);
      {mtx_er, mtx_d} = w;
      mtx_v = 1'b1;
      do begin
         r = mtx_rdy === 1'b1;
         @(negedge clk);
         n++;
      end while (!r && n < 4000);
   endtask : push_tx

   task automatic run_cfg(input logic m, input gmp_speed_e s);
      int n;
      rst_n = 1'b0;
      mode = m;
      speed = s;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      full_seen = 1'b0;
      fork
         begin
            for (int i = 0; i < 20; i++) push_rx(9'(rnd()));
            prx_v = 1'b0;
         end
         begin
            for (int i = 0; i < 20; i++) push_tx(9'(rnd()));
            mtx_v = 1'b0;
         end
      join
      n = 0;
      while (rxq.size() + txq.size() > 0 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      chk_bit(rxq.size() + txq.size() == 0, 1'b1);
      if (s == SPD_10) chk_bit(full_seen, 1'b1);
      repeat (4) begin
         {carrier, coll, fdx} = 3'(rnd());
         repeat (8) @(negedge clk);
         chk_bit(crs_o, !m && carrier);
         chk_bit(col_o, !m && coll && !fdx);
      end
   endtask : run_cfg

   // results are looked at mid-cycle, where the one-cycle pulses stand settled
   always @(negedge clk) begin
      cyc <= cyc + 1;
      if (mrx_v === 1'b1) begin
         chk_word({mrx_er, mrx_d}, rxq.size() > 0 ? rxq.pop_front() : 9'hX);
      end
      if (ptx_v === 1'b1) begin
         chk_word({ptx_er, ptx_d}, txq.size() > 0 ? txq.pop_front() : 9'hX);
      end
      if (cyc == 40000) begin
         fail_count++;
         summarize();
      end
   end

   initial begin
      repeat (12) @(negedge clk);
      for (int m = 0; m < 2; m++) begin
         for (int s = 0; s < 3; s++) begin
            run_cfg(m[0], gmp_speed_e'(s));
         end
      end
      summarize();
   end
endmodule : gmp_port_test
`default_nettype wire
